/* flash_pin_params.svh */
// constants shared by both ends of the flash pin interface
`ifndef FLASH_PIN_PARAMS_SVH
`define FLASH_PIN_PARAMS_SVH
`define AW 25
`define DW 16
`define MEM_AW 6
`define CNT_W 4
`define LAT_W 3
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_READ_CONFIG 8'h90
`define CMD_PROGRAM 8'h40
`define CMD_CFG_SETUP 8'h60
`define CMD_CFG_CONFIRM 8'h03
`define RCR_RESET 16'h8400
`define RCR_ASYNC_BIT 15
`define RCR_STALL_POL_BIT 10
`define RCR_LAT_MSB 13
`define RCR_LAT_LSB 11
`define STATUS_READY 16'h0080
`define ERASED_WORD 16'hffff
`define BUS_PULLUP 16'hffff
`define DENSITY_DEFAULT 512
`define WRITE_LOW_CYCLES 4'h2
`define ASYNC_READ_CYCLES 4'h3
`endif

/* flash_pin_pkg.sv */
// types shared by both ends of the flash pin interface
`include "flash_pin_params.svh"
package flash_pin_pkg;
  typedef logic [`AW-1:0] word_addr_t;
  typedef logic [`DW-1:0] word_t;
  typedef enum {MODE_ARRAY, MODE_STATUS, MODE_CONFIG, MODE_PROGRAM, MODE_CFG_SETUP} cmd_mode_t;
  typedef enum {H_IDLE, H_WR_LOW, H_WR_HIGH, H_AR_SETUP, H_AR_WAIT, H_SR_START, H_SR_RUN} host_state_t;
endpackage : flash_pin_pkg

/* flash_pins_if.sv */
// pin bundle between the flash device end and the host controller end
`timescale 1ns/1ps
`include "flash_pin_params.svh"
interface flash_pins_if;
  logic [`AW-1:0] addr;
  logic first_die_select_n;
  logic second_die_select_n;
  logic output_enable_n;
  logic second_die_output_enable_n;
  logic write_n;
  logic flash_reset_n;
  logic address_latch_strobe_n;
  logic flash_clk;
  logic [`DW-1:0] host_dq_out;
  logic host_dq_oe_n;
  logic [`DW-1:0] dev_dq_out;
  logic dev_dq_oe_n;
  logic [`DW-1:0] dq;
  logic stall_out;
  logic stall_oe_n;
  logic stall;
  // ************************************************
  // wire resolution, pull-up when nobody drives
  // ************************************************
  assign dq = !dev_dq_oe_n ? dev_dq_out : (!host_dq_oe_n ? host_dq_out : `BUS_PULLUP);
  assign stall = !stall_oe_n ? stall_out : 1'b1;
  modport device (input addr, first_die_select_n, second_die_select_n, output_enable_n,
    second_die_output_enable_n, write_n, flash_reset_n, address_latch_strobe_n, flash_clk, dq,
    output dev_dq_out, dev_dq_oe_n, stall_out, stall_oe_n);
  modport host (output addr, first_die_select_n, second_die_select_n, output_enable_n,
    second_die_output_enable_n, write_n, flash_reset_n, address_latch_strobe_n, flash_clk,
    host_dq_out, host_dq_oe_n, input dq, stall);
endinterface : flash_pins_if

/* flash_device_end.sv */
// flash device end: address latch, select, output enable, stall, commands and a small array
`timescale 1ns/1ps
`include "flash_pin_params.svh"
// Contract
// RQ1 - lowest address input is word address bit zero
// RQ2 - upper decoded address bit follows density
// RQ3 - top address bit high selects top die
// RQ4 - data lines take writes, drive read data
// RQ5 - data lines released if select or enable high
// RQ6 - sync read latches at strobe rise or clock
// RQ7 - async latches at strobe rise, else flows
// RQ8 - host not using strobe holds it low
// RQ9 - select low activates die, high means standby
// RQ10 - host keeps all selects high when idle
// RQ11 - clock used only for synchronous reads
// RQ12 - host without sync reads ties clock fixed
// RQ13 - drivers on only with output enable low
// RQ14 - thin package host uses asynchronous reads only
// RQ15 - stacked package shifts upper address bits down
// RQ16 - stacked package second die pins unused
// RQ17 - stall asserted while sync data invalid
// RQ18 - write latches address, data at strobe rise
// RQ19 - reset stops automation, returns to array read
module flash_device_end import flash_pin_pkg::*; #(
  parameter int DENSITY_MBIT = `DENSITY_DEFAULT,
  parameter bit STACKED_PACKAGE = 1'b0
) (
  flash_pins_if.device pins,
  input wire logic mclk,
  input wire logic rst_n,
  output logic standby,
  output logic selected_die,
  output logic sync_mode
);
  // ************************************************
  // address decode helpers
  // ************************************************
  function automatic logic [4:0] top_index(input int density, input bit stacked);
    int a_num;
    a_num = (density >= 512) ? 25 : (density >= 256) ? 24 : (density >= 128) ? 23 : 22; // RQ2
    if (stacked) begin
      a_num = a_num - 1; // RQ15
    end
    top_index = 5'(a_num - 1); // RQ1
  endfunction : top_index

  localparam logic [4:0] TOP = top_index(DENSITY_MBIT, STACKED_PACKAGE);
  localparam bit DUAL_DIE = (DENSITY_MBIT >= 512);

  // inputs above the density's top bit are not connected
  function automatic word_addr_t decode_addr(input word_addr_t a);
    decode_addr = a;
    for (int i = 0; i < `AW; i++) begin
      if (i > TOP) begin
        decode_addr[i] = 1'b0; // RQ2
      end
    end
  endfunction : decode_addr

  function automatic logic [`MEM_AW:0] mem_index(input word_addr_t a);
    mem_index = {(DUAL_DIE ? a[TOP] : 1'b0), a[`MEM_AW-1:0]}; // RQ3
  endfunction : mem_index

  // ************************************************
  // state
  // ************************************************
  logic [`DW-1:0] mem [0:(2**(`MEM_AW+1))-1];
  logic adv_q, we_q, clk_q, captured, burst_on, stall_act, stall_level;
  logic next_captured, next_burst_on, next_stall_act, next_stall_level, next_selected_die;
  logic [`LAT_W-1:0] lat_cnt, next_lat_cnt;
  word_addr_t latched_addr, burst_addr, next_latched_addr, next_burst_addr, cur_addr, eff_addr;
  word_t read_config_reg, next_rcr, dq_reg, next_dq, read_word;
  cmd_mode_t mode, next_mode;
  logic mem_we;
  logic [`MEM_AW:0] mem_widx;
  logic ce_act, oe_act, in_reset, sync_on, adv_rise, adv_fall, clk_rise, we_rise;

  // only the first die's select and enable are used
  assign ce_act = !pins.first_die_select_n; // RQ16
  assign oe_act = !pins.output_enable_n;
  assign in_reset = !pins.flash_reset_n;
  assign sync_on = !read_config_reg[`RCR_ASYNC_BIT];
  assign adv_rise = pins.address_latch_strobe_n && !adv_q;
  assign adv_fall = !pins.address_latch_strobe_n && adv_q;
  assign clk_rise = pins.flash_clk && !clk_q;
  assign we_rise = pins.write_n && !we_q;
  assign cur_addr = decode_addr(pins.addr);

  // ************************************************
  // pin drivers
  // ************************************************
  assign pins.dev_dq_out = dq_reg; // RQ4
  assign pins.dev_dq_oe_n = !(ce_act && oe_act && pins.write_n && !in_reset); // RQ5 RQ9 RQ13
  assign pins.stall_out = stall_level;
  assign pins.stall_oe_n = !(ce_act && oe_act); // RQ9 RQ13
  assign sync_mode = sync_on;

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb begin
    next_captured = captured;
    next_burst_on = burst_on;
    next_lat_cnt = lat_cnt;
    next_latched_addr = latched_addr;
    next_burst_addr = burst_addr;
    next_stall_act = stall_act;
    next_dq = dq_reg;
    next_mode = mode;
    next_rcr = read_config_reg;
    mem_we = 1'b0;
    mem_widx = mem_index(cur_addr);
    // address path
    if (sync_on) begin
      eff_addr = burst_addr;
    end else begin
      // on the rising edge itself the latch is only being loaded, so use the pins
      eff_addr = (pins.address_latch_strobe_n && !adv_rise) ? latched_addr : cur_addr; // RQ7
    end
    case (mode)
      MODE_STATUS: read_word = `STATUS_READY;
      MODE_CONFIG: read_word = read_config_reg;
      default: read_word = mem[mem_index(eff_addr)];
    endcase
    if (!ce_act || in_reset) begin
      next_captured = 1'b0;
      next_burst_on = 1'b0;
      next_stall_act = 1'b0;
    end else if (sync_on) begin
      // clock only matters here; async path never looks at it
      if ((adv_fall || !captured) && (adv_rise || (clk_rise && !pins.address_latch_strobe_n))) begin // RQ6 RQ11
        next_latched_addr = cur_addr;
        next_burst_addr = cur_addr;
        next_captured = 1'b1;
        next_burst_on = 1'b1;
        next_lat_cnt = read_config_reg[`RCR_LAT_MSB:`RCR_LAT_LSB];
        next_stall_act = 1'b1; // RQ17
      end else begin
        if (adv_fall) begin
          next_captured = 1'b0;
          next_burst_on = 1'b0;
        end
        if (burst_on && clk_rise) begin
          if (lat_cnt != '0) begin
            next_lat_cnt = lat_cnt - 1'b1;
            next_stall_act = 1'b1; // RQ17
          end else begin
            next_dq = read_word;
            next_burst_addr = burst_addr + 1'b1;
            next_stall_act = 1'b0; // RQ17
          end
        end
      end
    end else begin
      next_burst_on = 1'b0;
      next_stall_act = 1'b0; // RQ17
      if (adv_rise) begin
        next_latched_addr = cur_addr; // RQ7
      end
      next_dq = read_word;
    end
    // command path, writes blocked under reset
    if (in_reset) begin
      next_mode = MODE_ARRAY; // RQ19
      next_rcr = `RCR_RESET; // RQ19
    end else if (we_rise && ce_act) begin // RQ18
      next_stall_act = 1'b0; // RQ17
      case (mode)
        MODE_PROGRAM: begin
          mem_we = 1'b1; // RQ4
          next_mode = MODE_STATUS;
        end
        MODE_CFG_SETUP: begin
          if (pins.dq[7:0] == `CMD_CFG_CONFIRM) begin
            next_rcr = cur_addr[`DW-1:0];
          end
          next_mode = MODE_ARRAY;
        end
        default: begin
          case (pins.dq[7:0])
            `CMD_READ_STATUS: next_mode = MODE_STATUS;
            `CMD_READ_CONFIG: next_mode = MODE_CONFIG;
            `CMD_PROGRAM: next_mode = MODE_PROGRAM;
            `CMD_CFG_SETUP: next_mode = MODE_CFG_SETUP;
            default: next_mode = MODE_ARRAY;
          endcase
        end
      endcase
    end
    // polarity bit picks the asserted level
    next_stall_level = next_stall_act ~^ next_rcr[`RCR_STALL_POL_BIT]; // RQ17
    next_selected_die = DUAL_DIE ? eff_addr[TOP] : 1'b0; // RQ3
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adv_q <= 1'b1;
      we_q <= 1'b1;
      clk_q <= 1'b0;
      captured <= 1'b0;
      burst_on <= 1'b0;
      lat_cnt <= '0;
      latched_addr <= '0;
      burst_addr <= '0;
      stall_act <= 1'b0;
      stall_level <= 1'b0;
      dq_reg <= `ERASED_WORD;
      mode <= MODE_ARRAY;
      read_config_reg <= `RCR_RESET;
      standby <= 1'b1;
      selected_die <= 1'b0;
    end else begin
      adv_q <= pins.address_latch_strobe_n;
      we_q <= pins.write_n;
      clk_q <= pins.flash_clk;
      captured <= next_captured;
      burst_on <= next_burst_on;
      lat_cnt <= next_lat_cnt;
      latched_addr <= next_latched_addr;
      burst_addr <= next_burst_addr;
      stall_act <= next_stall_act;
      stall_level <= next_stall_level;
      dq_reg <= next_dq;
      mode <= next_mode;
      read_config_reg <= next_rcr;
      standby <= !ce_act; // RQ9
      selected_die <= next_selected_die;
    end
  end

  // array has no reset; contents survive like real cells
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_widx] <= pins.dq; // RQ18
    end
  end
endmodule : flash_device_end

/* flash_host_end.sv */
// host controller end: drives the flash pins for writes, async reads and sync bursts
`timescale 1ns/1ps
`include "flash_pin_params.svh"
module flash_host_end import flash_pin_pkg::*; #(
  parameter bit TSOP_PACKAGE = 1'b0
) (
  flash_pins_if.host pins,
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_sync,
  input wire logic [`AW-1:0] req_addr,
  input wire logic [`DW-1:0] req_wdata,
  input wire logic [`CNT_W-1:0] req_burst_words,
  input wire logic stall_active_high,
  output logic rsp_valid,
  output logic [`DW-1:0] rsp_data
);
  host_state_t state, next_state;
  logic [`CNT_W-1:0] cnt, next_cnt;
  logic ce_n, oe_n, we_n, adv_n, fclk, dq_oe_n;
  logic next_ce_n, next_oe_n, next_we_n, next_adv_n, next_fclk, next_dq_oe_n, next_rsp_valid;
  word_addr_t addr_r, next_addr_r;
  word_t data_r, next_data_r, next_rsp_data;

  assign req_ready = (state == H_IDLE);
  assign pins.addr = addr_r; // RQ3
  assign pins.first_die_select_n = ce_n;
  assign pins.second_die_select_n = 1'b1; // RQ10
  assign pins.output_enable_n = oe_n;
  assign pins.second_die_output_enable_n = 1'b1;
  assign pins.write_n = we_n;
  // thin package: strobe parked low so addresses flow through
  assign pins.address_latch_strobe_n = adv_n && !TSOP_PACKAGE; // RQ8 RQ14
  assign pins.flash_clk = fclk;
  assign pins.host_dq_out = data_r;
  assign pins.host_dq_oe_n = dq_oe_n;

  // ************************************************
  // access sequencer
  // ************************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_adv_n = adv_n;
    next_fclk = fclk;
    next_dq_oe_n = dq_oe_n;
    next_addr_r = addr_r;
    next_data_r = data_r;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    case (state)
      H_IDLE: begin
        next_ce_n = 1'b1; // RQ10
        next_oe_n = 1'b1;
        next_we_n = 1'b1;
        next_adv_n = 1'b1;
        next_fclk = 1'b0; // RQ12
        next_dq_oe_n = 1'b1;
        if (req_valid) begin
          next_addr_r = req_addr;
          next_data_r = req_wdata;
          next_ce_n = 1'b0;
          next_adv_n = 1'b0;
          if (req_write) begin
            next_we_n = 1'b0;
            next_dq_oe_n = 1'b0;
            next_cnt = `WRITE_LOW_CYCLES - 1'b1;
            next_state = H_WR_LOW;
          end else if (req_sync && !TSOP_PACKAGE) begin // RQ14
            next_cnt = req_burst_words;
            next_state = H_SR_START;
          end else begin
            next_state = H_AR_SETUP;
          end
        end
      end
      H_WR_LOW: begin
        if (cnt == '0) begin
          next_we_n = 1'b1; // RQ18
          next_state = H_WR_HIGH;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      H_WR_HIGH: begin
        next_dq_oe_n = 1'b1;
        next_ce_n = 1'b1; // RQ10
        next_adv_n = 1'b1;
        next_state = H_IDLE;
      end
      H_AR_SETUP: begin
        next_adv_n = 1'b1; // RQ7
        next_oe_n = 1'b0;
        next_cnt = `ASYNC_READ_CYCLES - 1'b1;
        next_state = H_AR_WAIT;
      end
      H_AR_WAIT: begin
        if (cnt == '0) begin
          next_rsp_valid = 1'b1;
          next_rsp_data = pins.dq;
          next_ce_n = 1'b1; // RQ10
          next_oe_n = 1'b1;
          next_state = H_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      H_SR_START: begin
        next_fclk = 1'b1; // RQ6
        next_state = H_SR_RUN;
      end
      H_SR_RUN: begin
        next_adv_n = 1'b1;
        next_oe_n = 1'b0;
        next_fclk = !fclk;
        // sample in the low phase, after the device has moved its outputs
        if (!fclk && (pins.stall != stall_active_high)) begin // RQ17
          next_rsp_valid = 1'b1;
          next_rsp_data = pins.dq;
          if (cnt <= `CNT_W'(1)) begin
            next_fclk = 1'b0; // RQ12
            next_ce_n = 1'b1; // RQ10
            next_oe_n = 1'b1;
            next_state = H_IDLE;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      cnt <= '0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      adv_n <= 1'b1;
      fclk <= 1'b0;
      dq_oe_n <= 1'b1;
      addr_r <= '0;
      data_r <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      pins.flash_reset_n <= 1'b0; // RQ19
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      adv_n <= next_adv_n;
      fclk <= next_fclk;
      dq_oe_n <= next_dq_oe_n;
      addr_r <= next_addr_r;
      data_r <= next_data_r;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      pins.flash_reset_n <= 1'b1;
    end
  end
endmodule : flash_host_end

/* flash_pin_sva.sv */
// checker watching the pins between the flash device end and the host end
`timescale 1ns/1ps
`include "flash_pin_params.svh"
module flash_pin_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`AW-1:0] addr,
  input wire logic first_die_select_n,
  input wire logic output_enable_n,
  input wire logic write_n,
  input wire logic flash_reset_n,
  input wire logic address_latch_strobe_n,
  input wire logic flash_clk,
  input wire logic [`DW-1:0] host_dq_out,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic stall_oe_n
);
  // ************************************************
  // pin relations
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_dq_release;
    (first_die_select_n || output_enable_n) |-> dev_dq_oe_n;
  endproperty
  a_dq_release: assert property (p_dq_release) else $error("dq driven while deselected");
  property p_stall_release;
    (first_die_select_n || output_enable_n) |-> stall_oe_n;
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("stall driven while off");
  property p_drive_on;
    (!first_die_select_n && !output_enable_n && flash_reset_n && write_n) |-> !dev_dq_oe_n;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("dq not driven in read");
  property p_reset_off;
    !flash_reset_n |-> (dev_dq_oe_n && stall_oe_n);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs driven in reset");
  // two quiet cycles in a row mean the host has no transfer open
  property p_idle_select;
    ($past(write_n && output_enable_n && address_latch_strobe_n) && write_n && output_enable_n
      && address_latch_strobe_n) |-> first_die_select_n;
  endproperty
  a_idle_select: assert property (p_idle_select) else $error("select low while idle");
  property p_clk_quiet;
    $changed(flash_clk) |-> (!first_die_select_n || !$past(first_die_select_n));
  endproperty
  a_clk_quiet: assert property (p_clk_quiet) else $error("clock moves while deselected");
  property p_write_qual;
    !write_n |-> (!first_die_select_n && !host_dq_oe_n && output_enable_n);
  endproperty
  a_write_qual: assert property (p_write_qual) else $error("write strobe unqualified");
  property p_write_pulse;
    $fell(write_n) |=> (!write_n && $stable(addr) && $stable(host_dq_out))
      ##1 (write_n && $stable(addr) && $stable(host_dq_out));
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse or hold wrong");
endmodule : flash_pin_sva

/* tb.sv */
// testbench joining the flash device end and the host end
`timescale 1ns/1ps
`include "flash_pin_params.svh"
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module tb import flash_pin_pkg::*;;
  logic mclk;
  logic rst_n;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic req_sync;
  word_addr_t req_addr;
  word_t req_wdata;
  logic [`CNT_W-1:0] req_burst_words;
  logic rsp_valid;
  word_t rsp_data;
  logic standby;
  logic selected_die;
  logic sync_mode;
  logic stall_hi;
  int err_total;
  int num_checks;
  word_t got[$];
  word_addr_t pa[3] = '{25'h0000004, 25'h0000005, 25'h1000005};
  word_t pd[3] = '{16'h1a2b, 16'h3c4d, 16'hc3c3};
  flash_pins_if pins();
  flash_device_end u_flash_device_end (.pins(pins), .mclk(mclk), .rst_n(rst_n), .standby(standby),
    .selected_die(selected_die), .sync_mode(sync_mode));
  // stall_hi must follow the polarity bit of whatever config word is loaded
  flash_host_end u_flash_host_end (.pins(pins), .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_sync(req_sync), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_burst_words(req_burst_words), .stall_active_high(stall_hi),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  flash_pin_sva u_flash_pin_sva (.mclk(mclk), .rst_n(rst_n), .addr(pins.addr),
    .first_die_select_n(pins.first_die_select_n), .output_enable_n(pins.output_enable_n),
    .write_n(pins.write_n), .flash_reset_n(pins.flash_reset_n),
    .address_latch_strobe_n(pins.address_latch_strobe_n), .flash_clk(pins.flash_clk),
    .host_dq_out(pins.host_dq_out), .host_dq_oe_n(pins.host_dq_oe_n), .dev_dq_oe_n(pins.dev_dq_oe_n),
    .stall_oe_n(pins.stall_oe_n));
  // ************************************************
  // bus tasks
  // ************************************************
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic issue(input logic wr, input logic sy, input word_addr_t a, input word_t d,
    input logic [`CNT_W-1:0] n);
    int i;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge mclk);
    if (req_ready !== 1'b1) begin
      err_total++;
      close_out();
    end
    req_valid = 1'b1;
    req_write = wr;
    req_sync = sy;
    req_addr = a;
    req_wdata = d;
    req_burst_words = n;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : issue
  task automatic collect(input int n);
    int i;
    got.delete();
    for (i = 0; i < 200 && got.size() < n; i++) begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) got.push_back(rsp_data);
    end
    if (got.size() < n) begin
      err_total++;
      close_out();
    end
  endtask : collect
  task automatic wr(input word_addr_t a, input word_t d);
    issue(1'b1, 1'b0, a, d, 4'h1);
  endtask : wr
  task automatic rd(input word_addr_t a);
    issue(1'b0, 1'b0, a, 16'h0000, 4'h1);
    collect(1);
  endtask : rd
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_idle();
    `CHK(standby, 1'b1, "standby after reset")
    `CHK(pins.dq, `BUS_PULLUP, "bus not released")
  endtask : t_idle
  // neighbouring words and both dies, so a dropped low bit or die bit shows
  task automatic t_program();
    int k;
    for (k = 0; k < 3; k++) begin
      wr(pa[k], 16'h0040);
      wr(pa[k], pd[k]);
      rd(pa[k]);
      `CHK(got[0], `STATUS_READY, "status after program")
    end
    wr(25'h0000000, 16'h00ff);
    for (k = 0; k < 3; k++) begin
      rd(pa[k]);
      `CHK(got[0], pd[k], "array word")
      `CHK(selected_die, pa[k][`AW-1], "die choice")
    end
  endtask : t_program
  task automatic t_config_read();
    wr(25'h0000000, 16'h0090);
    rd(25'h0000000);
    `CHK(got[0], `RCR_RESET, "config reset value")
  endtask : t_config_read
  task automatic t_sync_burst();
    word_t exp[4] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081};
    int k;
    // array cells start unknown, so burst words 6 and 7 are programmed here; 4 and 5 come from t_program
    wr(25'h0000006, 16'h0040);
    wr(25'h0000006, 16'h5e6f);
    wr(25'h0000007, 16'h0040);
    wr(25'h0000007, 16'h7081);
    wr(25'h0000400, 16'h0060);
    wr(25'h0000400, 16'h0003);
    wr(25'h0000000, 16'h00ff);
    `CHK(sync_mode, 1'b1, "sync mode set")
    issue(1'b0, 1'b1, 25'h0000004, 16'h0000, 4'h4);
    collect(4);
    for (k = 0; k < 4; k++) `CHK(got[k], exp[k], "burst word")
    `CHK(standby, 1'b0, "selected during burst")
    repeat (2) @(negedge mclk);
    `CHK(standby, 1'b1, "standby after burst")
    `CHK(pins.first_die_select_n, 1'b1, "select after burst")
    `CHK(pins.dq, `BUS_PULLUP, "bus after burst")
  endtask : t_sync_burst
  // active-low stall and one latency clock: a polarity slip hands over stale data
  task automatic t_sync_low();
    wr(25'h0000800, 16'h0060);
    wr(25'h0000800, 16'h0003);
    wr(25'h0000000, 16'h00ff);
    stall_hi = 1'b0;
    issue(1'b0, 1'b1, pa[0], 16'h0000, 4'h2);
    collect(2);
    `CHK(got[0], pd[0], "low stall word 0")
    `CHK(got[1], pd[1], "low stall word 1")
  endtask : t_sync_low
  task automatic t_reset_again();
    rst_n = 1'b0;
    stall_hi = 1'b1;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK(sync_mode, 1'b0, "async after reset")
    t_config_read();
    wr(25'h0000000, 16'h00ff);
    rd(pa[0]);
    `CHK(got[0], pd[0], "array kept over reset")
  endtask : t_reset_again
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    err_total = 0;
    num_checks = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_sync = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_burst_words = 4'h1;
    stall_hi = 1'b1;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_idle();
    t_program();
    t_config_read();
    t_sync_burst();
    t_sync_low();
    t_reset_again();
    close_out();
  end
endmodule : tb
